// ===== src/fpac_pkg.sv
// constants and types for the flash program access control block
package fpac_pkg;
  // ****************************************
  // array geometry
  // ****************************************
  localparam logic [5:0] ROW_BYTES = 6'h20;
  localparam logic [13:0] ADDR_ONE = 14'h0001;
  localparam logic [13:0] EEPROM_LIMIT = 14'h0100;
  localparam logic [13:0] OPTION_LIMIT = 14'h0020;
  // boot sector size selected by the option byte, index 0 is the smallest
  localparam logic [3:0][13:0] SECT0_SIZE = {14'h1000, 14'h0800, 14'h0400, 14'h0200};
  localparam logic [1:0] SECT0_SEL_RESET = 2'h0;

  // ****************************************
  // address spaces of a request
  // ****************************************
  localparam logic [1:0] SPACE_FLASH = 2'h0;
  localparam logic [1:0] SPACE_OPTION = 2'h1;
  localparam logic [1:0] SPACE_EEPROM = 2'h2;

  // ****************************************
  // serial mode entry
  // ****************************************
  localparam logic [5:0] PULSES_STD = 6'h24;
  localparam logic [5:0] PULSES_OPT = 6'h26;
  localparam logic [5:0] PULSES_MAX = 6'h3F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [9:0] RAM_BASE = 10'h000;
  localparam logic [9:0] RAM_STEP = 10'h001;

  typedef enum logic [1:0] {
    PH_RUN,
    PH_LEN,
    PH_LOAD,
    PH_EXEC
  } fpac_phase_t;

  typedef struct packed {
    logic rst_n_s1;
    logic rst_n_s2;
    logic rst_n_d;
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic dat_s1;
    logic dat_s2;
    logic sock_s1;
    logic sock_s2;
    logic [5:0] pulse_cnt;
    fpac_phase_t ph;
    logic in_circuit_comm_mode;
    logic force_rc;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] load_left;
    logic [9:0] ram_ptr;
    logic [9:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic run_ram;
    logic [13:0] sect0;
    logic arr_we;
    logic arr_erase;
    logic [13:0] arr_addr;
    logic [5:0] arr_len;
    logic [1:0] arr_space;
    logic deny;
  } fpac_state_t;
endpackage

// ===== src/fpac_top.sv
// flash program access control: mode detection, loader download, write gating
// Operation
// - erase and program go one byte at a time or up to 32 bytes of one row in one operation.
// - an operation never reaches past the sector it starts in, so other sectors stay intact.
// - the boot sector size comes from the option byte setting, not a fixed value.
// - in the programming socket both sectors, the option row and the data eeprom are writable.
// - in serial programming mode the same regions are writable as in the socket.
// - under firmware control only sector 1 and the data eeprom are writable, with the app running.
// - under firmware control every write or erase to sector 0 is blocked.
// - serial mode is entered only when the defined clock sequence is seen while reset pin is low.
// - on entering serial mode the reset vector points into system memory.
// - loader bytes shifted in on the data pin are stored in ram and then run from ram.
// - entry through the option-enabled variant forces the internal rc oscillator.
`timescale 1ns/1ps
`default_nettype none
module fpac_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic serial_prog_clock_pin_i,
  input wire logic serial_prog_data_pin_i,
  input wire logic socket_mode_i,
  input wire logic [1:0] opt_sect0_sel_i,
  input wire logic opt_entry_en_i,
  input wire logic req_i,
  input wire logic req_erase_i,
  input wire logic [1:0] req_space_i,
  input wire logic [13:0] req_addr_i,
  input wire logic [5:0] req_len_i,
  output logic arr_we_o,
  output logic arr_erase_o,
  output logic [13:0] arr_addr_o,
  output logic [5:0] arr_len_o,
  output logic [1:0] arr_space_o,
  output logic deny_o,
  output logic [13:0] sect0_size_o,
  output logic in_circuit_comm_mode_o,
  output logic vector_sys_o,
  output logic force_rc_o,
  output logic ram_we_o,
  output logic [9:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic run_ram_o
);

  // ****************************************
  // state
  // ****************************************
  fpac_pkg::fpac_state_t st;
  fpac_pkg::fpac_state_t next_st;

  logic clk_rise;
  logic pin_release;
  logic entry_std;
  logic entry_opt;
  logic [6:0] row_end;
  logic [13:0] last_addr;
  logic first_s0;
  logic last_s0;
  logic fmt_ok;
  logic privileged;
  logic allowed;
  logic [7:0] byte_in;

  // ****************************************
  // request checks
  // ****************************************
  always_comb begin
    // seven bits, so a length up to 63 cannot wrap past the row check
    row_end = {2'b00, req_addr_i[4:0]} + {1'b0, req_len_i};
    last_addr = req_addr_i + {8'h00, req_len_i} - fpac_pkg::ADDR_ONE;
    first_s0 = req_addr_i < st.sect0;
    last_s0 = last_addr < st.sect0;
    fmt_ok = (req_len_i != 6'h00) && (row_end <= {1'b0, fpac_pkg::ROW_BYTES});
    if (req_space_i == fpac_pkg::SPACE_FLASH) begin
      fmt_ok = fmt_ok && (first_s0 == last_s0);
    end else if (req_space_i == fpac_pkg::SPACE_OPTION) begin
      fmt_ok = fmt_ok && (req_addr_i < fpac_pkg::OPTION_LIMIT);
    end else if (req_space_i == fpac_pkg::SPACE_EEPROM) begin
      fmt_ok = fmt_ok && (req_addr_i < fpac_pkg::EEPROM_LIMIT);
    end else begin
      fmt_ok = 1'b0;
    end
    // socket and serial modes share one set of rights
    privileged = st.sock_s2 || st.in_circuit_comm_mode;
    if (privileged) begin
      allowed = 1'b1;
    end else if (req_space_i == fpac_pkg::SPACE_EEPROM) begin
      allowed = 1'b1;
    end else if (req_space_i == fpac_pkg::SPACE_FLASH) begin
      allowed = !first_s0;
    end else begin
      allowed = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rst_n_s1 = ext_reset_n_i;
    next_st.rst_n_s2 = st.rst_n_s1;
    next_st.rst_n_d = st.rst_n_s2;
    next_st.clk_s1 = serial_prog_clock_pin_i;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_d = st.clk_s2;
    next_st.dat_s1 = serial_prog_data_pin_i;
    next_st.dat_s2 = st.dat_s1;
    next_st.sock_s1 = socket_mode_i;
    next_st.sock_s2 = st.sock_s1;
    next_st.sect0 = fpac_pkg::SECT0_SIZE[opt_sect0_sel_i];
    next_st.ram_we = 1'b0;
    next_st.arr_we = 1'b0;
    next_st.arr_erase = 1'b0;
    next_st.deny = 1'b0;
    clk_rise = st.clk_s2 && !st.clk_d;
    pin_release = st.rst_n_s2 && !st.rst_n_d;
    entry_opt = pin_release && opt_entry_en_i && (st.pulse_cnt == fpac_pkg::PULSES_OPT);
    entry_std = pin_release && (st.pulse_cnt == fpac_pkg::PULSES_STD);
    byte_in = {st.shreg[6:0], st.dat_s2};

    if (!st.rst_n_s2) begin
      // reset pin held by the tool: count clock pulses of the entry sequence
      next_st.in_circuit_comm_mode = 1'b0;
      next_st.force_rc = 1'b0;
      next_st.run_ram = 1'b0;
      next_st.ph = fpac_pkg::PH_RUN;
      next_st.bit_cnt = 3'h0;
      next_st.ram_ptr = fpac_pkg::RAM_BASE;
      if (st.rst_n_d) begin
        next_st.pulse_cnt = 6'h00;
      end else if (clk_rise && (st.pulse_cnt != fpac_pkg::PULSES_MAX)) begin
        next_st.pulse_cnt = st.pulse_cnt + 6'h01;
      end
    end else if (pin_release) begin
      if (entry_opt || entry_std) begin
        next_st.in_circuit_comm_mode = 1'b1;
        next_st.force_rc = entry_opt;
        next_st.ph = fpac_pkg::PH_LEN;
      end
    end else if (clk_rise && ((st.ph == fpac_pkg::PH_LEN) || (st.ph == fpac_pkg::PH_LOAD))) begin
      // msb first, one bit per rising clock edge
      next_st.shreg = byte_in;
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == fpac_pkg::BIT_LAST) begin
        if (st.ph == fpac_pkg::PH_LEN) begin
          next_st.load_left = byte_in;
          if (byte_in == 8'h00) begin
            next_st.ph = fpac_pkg::PH_EXEC;
            next_st.run_ram = 1'b1;
          end else begin
            next_st.ph = fpac_pkg::PH_LOAD;
          end
        end else begin
          next_st.ram_we = 1'b1;
          next_st.ram_wdata = byte_in;
          next_st.ram_addr = st.ram_ptr;
          next_st.ram_ptr = st.ram_ptr + fpac_pkg::RAM_STEP;
          next_st.load_left = st.load_left - fpac_pkg::BYTE_ONE;
          if (st.load_left == fpac_pkg::BYTE_ONE) begin
            next_st.ph = fpac_pkg::PH_EXEC;
            next_st.run_ram = 1'b1;
          end
        end
      end
    end

    if (req_i) begin
      if (fmt_ok && allowed) begin
        next_st.arr_we = 1'b1;
        next_st.arr_erase = req_erase_i;
        next_st.arr_addr = req_addr_i;
        next_st.arr_len = req_len_i;
        next_st.arr_space = req_space_i;
      end else begin
        next_st.deny = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      // clock pin idles high, so its edge detector starts high too
      st <= '{rst_n_s1: 1'b1, rst_n_s2: 1'b1, rst_n_d: 1'b1, clk_s1: 1'b1, clk_s2: 1'b1,
              clk_d: 1'b1, ph: fpac_pkg::PH_RUN,
              sect0: fpac_pkg::SECT0_SIZE[fpac_pkg::SECT0_SEL_RESET], default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign arr_we_o = st.arr_we;
  assign arr_erase_o = st.arr_erase;
  assign arr_addr_o = st.arr_addr;
  assign arr_len_o = st.arr_len;
  assign arr_space_o = st.arr_space;
  assign deny_o = st.deny;
  assign sect0_size_o = st.sect0;
  assign in_circuit_comm_mode_o = st.in_circuit_comm_mode;
  // the system memory vector stays selected for as long as serial mode lasts
  assign vector_sys_o = st.in_circuit_comm_mode;
  assign force_rc_o = st.force_rc;
  assign ram_we_o = st.ram_we;
  assign ram_addr_o = st.ram_addr;
  assign ram_wdata_o = st.ram_wdata;
  assign run_ram_o = st.run_ram;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_req_good;
    req_i && fmt_ok;
  endsequence

  sequence s_entry;
    st.rst_n_s2 && !st.rst_n_d && (entry_std || entry_opt);
  endsequence

  sequence s_last_load;
    (st.ph == fpac_pkg::PH_LOAD) && clk_rise && (st.bit_cnt == fpac_pkg::BIT_LAST)
      && (st.load_left == fpac_pkg::BYTE_ONE);
  endsequence

  sequence s_load_byte;
    (st.ph == fpac_pkg::PH_LOAD) && clk_rise && (st.bit_cnt == fpac_pkg::BIT_LAST);
  endsequence

  a_row_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    arr_we_o |-> (arr_len_o != 6'h00)
      && (({2'b00, arr_addr_o[4:0]} + {1'b0, arr_len_o}) <= 7'h20))
    else $error("array operation crosses a row");

  a_sector_stay: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_i && (req_space_i == fpac_pkg::SPACE_FLASH) && (first_s0 != last_s0) |=> deny_o)
    else $error("operation spanning two sectors not refused");

  a_boot_size: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 sect0_size_o == fpac_pkg::SECT0_SIZE[$past(opt_sect0_sel_i)])
    else $error("boot sector size does not follow option byte");

  a_socket_rights: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_req_good and st.sock_s2 |=> arr_we_o && (arr_addr_o == $past(req_addr_i)))
    else $error("socket mode write refused");

  a_serial_rights: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_req_good and in_circuit_comm_mode_o |=> arr_we_o && !deny_o)
    else $error("serial mode write refused");

  a_fw_sector1: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_req_good and !privileged && ((req_space_i == fpac_pkg::SPACE_EEPROM)
      || ((req_space_i == fpac_pkg::SPACE_FLASH) && !first_s0)) |=> arr_we_o)
    else $error("firmware write to sector 1 or eeprom refused");

  a_fw_block_s0: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_i && !privileged && (req_space_i != fpac_pkg::SPACE_EEPROM)
      && ((req_space_i != fpac_pkg::SPACE_FLASH) || first_s0) |=> deny_o && !arr_we_o)
    else $error("firmware write to protected region passed");

  a_entry_only: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(in_circuit_comm_mode_o) |-> $past(entry_std || entry_opt))
    else $error("serial mode entered without entry sequence");

  a_entry_vector: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_entry |=> vector_sys_o && in_circuit_comm_mode_o)
    else $error("system vector not selected on entry");

  a_ram_store: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_last_load |=> ram_we_o && run_ram_o && (ram_wdata_o == $past(byte_in)))
    else $error("last loader byte not stored or not run");

  a_rc_forced: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_entry and entry_opt) |=> force_rc_o [*2])
    else $error("rc oscillator not forced on option entry");

  a_deny_clean: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_i && !(fmt_ok && allowed) |=> deny_o && !arr_we_o && $stable(arr_addr_o))
    else $error("forbidden operation reached the array");

  a_idle_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    !req_i |=> !arr_we_o && !deny_o)
    else $error("array strobe without a request");

  a_issue_copy: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_req_good and allowed |=> arr_we_o && (arr_len_o == $past(req_len_i))
      && (arr_space_o == $past(req_space_i)) && (arr_erase_o == $past(req_erase_i)))
    else $error("issued operation differs from request");

  // a held reset pin drops serial mode, so a later normal boot is clean
  a_pin_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    !st.rst_n_s2 |=> !in_circuit_comm_mode_o && !force_rc_o && !run_ram_o)
    else $error("serial mode survives reset pin");

  a_count_miss: assert property (@(posedge mclk_i) disable iff (rst_i)
    pin_release && !entry_std && !entry_opt |=> !in_circuit_comm_mode_o)
    else $error("serial mode entered on wrong pulse count");

  a_rc_std: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_entry and !entry_opt) |=> !force_rc_o)
    else $error("rc forced on standard entry");

  a_ram_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_load_byte |=> ram_we_o && (ram_addr_o == $past(st.ram_ptr)))
    else $error("loader byte not stored at next ram address");

endmodule // fpac_top
`default_nettype wire

// ===== testbench/flash_program_access_control_tb.sv
// self-checking bench for the flash program access control block
`timescale 1ns/1ps
`default_nettype none
module flash_program_access_control_tb;
  logic mclk, rst, sock, ent, rq, er;
  logic [1:0] sel, sp, as;
  logic [13:0] ad, aa, s0;
  logic [5:0] ln, al;
  logic rn, sck, sda, we, ers, dn, in_circuit_comm_mode, vec, frc, rwe, run;
  logic [9:0] ra;
  logic [7:0] rd;
  logic [18:0] ram_log[$];
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  fpac_tool i_fpac_tool (
    .mclk_i(mclk), .ext_reset_n_o(rn), .serial_prog_clock_pin_o(sck),
    .serial_prog_data_pin_o(sda)
  );
  fpac_top i_fpac_top (
    .mclk_i(mclk), .rst_i(rst), .ext_reset_n_i(rn), .serial_prog_clock_pin_i(sck),
    .serial_prog_data_pin_i(sda), .socket_mode_i(sock), .opt_sect0_sel_i(sel),
    .opt_entry_en_i(ent), .req_i(rq), .req_erase_i(er), .req_space_i(sp),
    .req_addr_i(ad), .req_len_i(ln), .arr_we_o(we), .arr_erase_o(ers),
    .arr_addr_o(aa), .arr_len_o(al), .arr_space_o(as), .deny_o(dn),
    .sect0_size_o(s0), .in_circuit_comm_mode_o(in_circuit_comm_mode), .vector_sys_o(vec),
    .force_rc_o(frc), .ram_we_o(rwe), .ram_addr_o(ra), .ram_wdata_o(rd), .run_ram_o(run)
  );
  // ****************************************
  // clock, log and helpers
  // ****************************************
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rwe === 1'h1) begin
      ram_log.push_back({run, ra, rd});
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_req(input logic e, input logic [1:0] s, input logic [13:0] a,
                        input logic [5:0] n, input logic ok);
    @(posedge mclk);
    rq <= 1'h1;
    er <= e;
    sp <= s;
    ad <= a;
    ln <= n;
    @(posedge mclk);
    rq <= 1'h0;
    #1;
    check("issue", {we, dn}, {ok, !ok});
    if (ok) check("fields", {ers, as, aa, al}, {e, s, a, n});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sect0();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      sel <= i[1:0];
      repeat (2) @(posedge mclk);
      #1;
      check("boot size", s0, 14'h0200 << i);
    end
    @(posedge mclk);
    sel <= 2'h0;
  endtask
  task automatic t_firmware();
    do_req(1'h0, 2'h0, 14'h0000, 6'h01, 1'h0);
    do_req(1'h1, 2'h0, 14'h01E0, 6'h20, 1'h0);
    do_req(1'h0, 2'h0, 14'h0200, 6'h01, 1'h1);
    do_req(1'h1, 2'h0, 14'h0220, 6'h20, 1'h1);
    do_req(1'h0, 2'h1, 14'h0000, 6'h01, 1'h0);
    do_req(1'h1, 2'h2, 14'h00E0, 6'h20, 1'h1);
    do_req(1'h0, 2'h0, 14'h0201, 6'h20, 1'h0);
    do_req(1'h0, 2'h0, 14'h0240, 6'h00, 1'h0);
    do_req(1'h0, 2'h0, 14'h021F, 6'h3F, 1'h0);
    @(posedge mclk);
    sel <= 2'h3;
    do_req(1'h0, 2'h0, 14'h0FE0, 6'h20, 1'h0);
    do_req(1'h0, 2'h0, 14'h1000, 6'h20, 1'h1);
    @(posedge mclk);
    sel <= 2'h0;
  endtask
  task automatic t_socket();
    @(posedge mclk);
    sock <= 1'h1;
    repeat (4) @(posedge mclk);
    do_req(1'h1, 2'h0, 14'h0000, 6'h20, 1'h1);
    do_req(1'h0, 2'h1, 14'h001F, 6'h01, 1'h1);
    do_req(1'h0, 2'h2, 14'h00FF, 6'h01, 1'h1);
    do_req(1'h0, 2'h2, 14'h0100, 6'h01, 1'h0);
    do_req(1'h1, 2'h0, 14'h01F0, 6'h20, 1'h0);
    do_req(1'h0, 2'h3, 14'h0000, 6'h01, 1'h0);
    @(posedge mclk);
    sock <= 1'h0;
  endtask
  task automatic t_serial();
    i_fpac_tool.enter(36);
    #1;
    check("mode", {in_circuit_comm_mode, vec, frc, run}, 4'hC);
    do_req(1'h0, 2'h0, 14'h0000, 6'h01, 1'h1);
    do_req(1'h1, 2'h1, 14'h0000, 6'h20, 1'h1);
    i_fpac_tool.send_byte(8'h02);
    i_fpac_tool.send_byte(8'hA5);
    i_fpac_tool.send_byte(8'h3C);
    repeat (8) @(posedge mclk);
    #1;
    check("ram writes", ram_log.size(), 32'h2);
    check("ram first", ram_log[0], {1'h0, 10'h000, 8'hA5});
    check("ram last", ram_log[1], {1'h1, 10'h001, 8'h3C});
    check("run ram", run, 1'h1);
  endtask
  task automatic t_entry();
    i_fpac_tool.enter(35);
    #1;
    check("wrong count", {in_circuit_comm_mode, vec, frc, run}, 4'h0);
    // 38 pulses enter only with the option bit set
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk);
      ent <= v[0];
      i_fpac_tool.enter(38);
      #1;
      check("forced rc", {in_circuit_comm_mode, vec, frc}, {3{v[0]}});
    end
    // zero length loader runs at once with no ram write
    i_fpac_tool.send_byte(8'h00);
    #1;
    check("empty run", run, 1'h1);
    check("empty writes", ram_log.size(), 32'h2);
  endtask
  initial begin
    rst = 1'h1;
    sock = 1'h0;
    ent = 1'h0;
    rq = 1'h0;
    er = 1'h0;
    sel = 2'h0;
    sp = 2'h0;
    ad = 14'h0000;
    ln = 6'h01;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    check("boot size", s0, 14'h0200);
    t_sect0();
    t_firmware();
    t_socket();
    t_serial();
    t_entry();
    print_verdict();
  end
endmodule // flash_program_access_control_tb
`default_nettype wire

// ===== testbench/fpac_tool.sv
// programming tool model: drives the reset pin and the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module fpac_tool (
  input wire logic mclk_i,
  output var logic ext_reset_n_o,
  output var logic serial_prog_clock_pin_o,
  output var logic serial_prog_data_pin_o
);
  // clock pin pulled up, so it rests high between frames
  initial begin
    ext_reset_n_o = 1'h1;
    serial_prog_clock_pin_o = 1'h1;
    serial_prog_data_pin_o = 1'h1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one link period of 125 ns is 25 mclk cycles
  task automatic pulse();
    serial_prog_clock_pin_o <= 1'h0;
    wait_cyc(13);
    serial_prog_clock_pin_o <= 1'h1;
    wait_cyc(12);
  endtask
  // reset pin held low for the whole pulse train
  task automatic enter(input int n);
    wait_cyc(1);
    ext_reset_n_o <= 1'h0;
    wait_cyc(6);
    repeat (n) pulse();
    ext_reset_n_o <= 1'h1;
    wait_cyc(12);
  endtask
  // msb first, data settles while the clock is low
  task automatic send_byte(input logic [7:0] b);
    wait_cyc(1);
    for (int i = 7; i >= 0; i--) begin
      serial_prog_data_pin_o <= b[i];
      pulse();
    end
    // released data line must not keep showing the last bit
    serial_prog_data_pin_o <= ~b[0];
  endtask
endmodule // fpac_tool
`default_nettype wire
